// *** hw/ods_cfg.svh ***
`ifndef ODS_CFG_SVH
`define ODS_CFG_SVH
`define ODS_CODE_MAX 5'h0D
`define ODS_LEVEL_DUP_LO 6'h20
`define ODS_LEVEL_DUP_HI 6'h2F
`define ODS_LEVEL_FOLD 6'h1F
`define ODS_SETTLE_NS 2000
`define ODS_CLK_NS 20
`define ODS_SETTLE_CYC ((`ODS_SETTLE_NS + `ODS_CLK_NS - 1) / `ODS_CLK_NS)
`define ODS_CAL_CYC 64
`endif

// *** hw/ods_pkg.sv ***
package ods_pkg;
  typedef enum logic [1:0] {ODS_SEL_DIV, ODS_SEL_VCO, ODS_SEL_SYSREF, ODS_SEL_OFF} ods_sel_t;
  typedef enum logic [1:0] {ODS_PH_IDLE, ODS_PH_CAL, ODS_PH_SETTLE, ODS_PH_MOD} ods_phase_t;
endpackage

// *** hw/ods_if.sv ***
`timescale 1ns/1ps
interface ods_if;
  import ods_pkg::*;
  logic [4:0] chan_div_code;
  ods_sel_t out_a_select;
  ods_sel_t out_b_select;
  logic [5:0] out_a_level_code;
  logic [5:0] out_b_level_code;
  logic pd_bit;
  logic cal_pin;
  logic cal_start_bit;
  logic phase_sync_en;
  logic align_pin_mask;
  logic sync_pin;
  logic frac_mode;
  logic [7:0] modulator_reset_count;
  logic phase_aligned;
  logic powered_down;
  modport dev (input chan_div_code, out_a_select, out_b_select, out_a_level_code, out_b_level_code, pd_bit,
    cal_pin, cal_start_bit, phase_sync_en, align_pin_mask, sync_pin, frac_mode, modulator_reset_count,
    output phase_aligned, powered_down);
  modport host (output chan_div_code, out_a_select, out_b_select, out_a_level_code, out_b_level_code, pd_bit,
    cal_pin, cal_start_bit, phase_sync_en, align_pin_mask, sync_pin, frac_mode, modulator_reset_count,
    input phase_aligned, powered_down);
endinterface

// *** hw/ods_device.sv ***
`timescale 1ns/1ps
`include "ods_cfg.svh"
module ods_device #(
  parameter int CAL_CYC = `ODS_CAL_CYC,
  parameter int SETTLE_CYC = `ODS_SETTLE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  ods_if.dev link,
  output logic [7:0] total_ratio_o,
  output logic [1:0] div_stage_first_o,
  output logic [1:0] div_stage_second_o,
  output logic [3:0] div_stage_third_o,
  output logic [2:0] div_stage_fourth_o,
  output logic code_valid_o,
  output logic div_powered_o,
  output logic [2:0] feedback_extra_div_o,
  output logic [5:0] out_a_level_o,
  output logic [5:0] out_b_level_o,
  output logic out_a_enabled_o,
  output logic out_b_enabled_o,
  output logic calibrating_o,
  output logic sync_event_o
);
  import ods_pkg::*;

  // segment table per code; first segment fixed at 2
  function automatic logic [10:0] seg_lookup(input logic [4:0] c);
    logic [10:0] r;
    r = {2'h2, 2'h1, 4'h1, 3'h1};
    unique case (c)
      5'h00: r = {2'h2, 2'h1, 4'h1, 3'h1};
      5'h01: r = {2'h2, 2'h2, 4'h1, 3'h1};
      5'h02: r = {2'h2, 2'h3, 4'h1, 3'h1};
      5'h03: r = {2'h2, 2'h2, 4'h2, 3'h1};
      5'h04: r = {2'h2, 2'h3, 4'h2, 3'h1};
      5'h05: r = {2'h2, 2'h2, 4'h4, 3'h1};
      5'h06: r = {2'h2, 2'h3, 4'h4, 3'h1};
      5'h07: r = {2'h2, 2'h2, 4'h8, 3'h1};
      5'h08: r = {2'h2, 2'h3, 4'h8, 3'h1};
      5'h09: r = {2'h2, 2'h2, 4'h8, 3'h2};
      5'h0A: r = {2'h2, 2'h3, 4'h6, 3'h2};
      5'h0B: r = {2'h2, 2'h3, 4'h8, 3'h2};
      5'h0C: r = {2'h2, 2'h2, 4'h8, 3'h4};
      5'h0D: r = {2'h2, 2'h3, 4'h8, 3'h4};
      default: r = {2'h2, 2'h1, 4'h1, 3'h1};
    endcase
    return r;
  endfunction

  // level codes in the duplicate band act as the top of the lower band
  function automatic logic [5:0] level_fold(input logic [5:0] v);
    return (v >= `ODS_LEVEL_DUP_LO && v <= `ODS_LEVEL_DUP_HI) ? `ODS_LEVEL_FOLD : v;
  endfunction

  wire [10:0] segs = seg_lookup(link.chan_div_code);
  wire [1:0] s0 = segs[10:9];
  wire [1:0] s1 = segs[8:7];
  wire [3:0] s2 = segs[6:3];
  wire [2:0] s3 = segs[2:0];
  wire [13:0] ratio_full = 14'(s0) * 14'(s1) * 14'(s2) * 14'(s3);
  wire [7:0] ratio = ratio_full[7:0];
  wire valid = link.chan_div_code <= `ODS_CODE_MAX;
  wire a_div = link.out_a_select == ODS_SEL_DIV;
  wire b_div = link.out_b_select == ODS_SEL_DIV || link.out_b_select == ODS_SEL_SYSREF;
  // the divider's own powerdown is deliberately not an input here
  wire next_div_pwr = a_div || b_div;
  wire both_direct = link.out_a_select == ODS_SEL_VCO && link.out_b_select == ODS_SEL_VCO;
  // every ratio divisible by three has a second segment of three
  wire by_three = s1 == 2'h3;
  wire three_excl = by_three && ratio != 8'h18 && ratio != 8'hC0;
  // the extra divide matters only while phase sync is on
  wire [2:0] extra_used = three_excl ? 3'h6 : 3'h4;
  wire [2:0] next_extra = (!link.phase_sync_en || both_direct) ? 3'h1 : extra_used;
  // pin low or bit high is enough on its own to power down
  wire pd_now = link.pd_bit || !link.cal_pin;

  logic pd_q;
  logic cal_q;
  logic en_q;
  logic pin_q;
  logic pin_rs;
  ods_phase_t ph;
  logic [15:0] cnt;

  // software edge on the enable bit, or the reclocked pin edge when unmasked
  wire pin_rise = pin_rs && !pin_q;
  wire soft_edge = link.phase_sync_en && !en_q;
  // a pin edge counts only while sync is on and the pin is unmasked
  wire pin_edge = link.phase_sync_en && !link.align_pin_mask && pin_rise;
  wire sync_ev = soft_edge || pin_edge;
  // a held calibration bit must not restart the sequence every cycle
  wire cal_req = link.cal_start_bit && !cal_q && !pd_now;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pd_q <= 1'b0;
      cal_q <= 1'b0;
      en_q <= 1'b0;
      pin_rs <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      pd_q <= pd_now;
      cal_q <= link.cal_start_bit;
      en_q <= link.phase_sync_en;
      pin_rs <= link.sync_pin;
      pin_q <= pin_rs;
    end
  end

  // alignment sequence; powerdown aborts and a fresh calibration restarts it
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ph <= ODS_PH_IDLE;
      cnt <= 16'h0000;
      link.phase_aligned <= 1'b0;
    end else if (pd_now) begin
      ph <= ODS_PH_IDLE;
      cnt <= 16'h0000;
      link.phase_aligned <= 1'b0;
    end else if (sync_ev || cal_req) begin
      ph <= ODS_PH_CAL;
      cnt <= 16'h0000;
      link.phase_aligned <= 1'b0;
    end else begin
      unique case (ph)
        ODS_PH_IDLE: cnt <= 16'h0000;
        ODS_PH_CAL: begin
          cnt <= (cnt == 16'(CAL_CYC - 1)) ? 16'h0000 : cnt + 16'h0001;
          if (cnt == 16'(CAL_CYC - 1)) ph <= ODS_PH_SETTLE;
        end
        ODS_PH_SETTLE: begin
          cnt <= (cnt == 16'(SETTLE_CYC - 1)) ? 16'h0000 : cnt + 16'h0001;
          if (cnt == 16'(SETTLE_CYC - 1)) begin
            ph <= link.frac_mode ? ODS_PH_MOD : ODS_PH_IDLE;
            link.phase_aligned <= !link.frac_mode && link.phase_sync_en;
          end
        end
        ODS_PH_MOD: begin
          cnt <= cnt + 16'h0001;
          if (cnt >= {8'h00, link.modulator_reset_count}) begin
            ph <= ODS_PH_IDLE;
            cnt <= 16'h0000;
            link.phase_aligned <= link.phase_sync_en;
          end
        end
      endcase
    end
  end

  // ratio and stages are registered together so they never disagree for a cycle
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      total_ratio_o <= 8'h02;
      div_stage_first_o <= 2'h2;
      div_stage_second_o <= 2'h1;
      div_stage_third_o <= 4'h1;
      div_stage_fourth_o <= 3'h1;
      code_valid_o <= 1'b1;
      feedback_extra_div_o <= 3'h1;
    end else begin
      total_ratio_o <= ratio;
      div_stage_first_o <= s0;
      div_stage_second_o <= s1;
      div_stage_third_o <= s2;
      div_stage_fourth_o <= s3;
      code_valid_o <= valid;
      feedback_extra_div_o <= next_extra;
    end
  end

  // the divider's supply follows the selections only, but powerdown still wins
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_powered_o <= 1'b0;
      sync_event_o <= 1'b0;
    end else begin
      div_powered_o <= next_div_pwr && !pd_now;
      sync_event_o <= sync_ev && !pd_now;
    end
  end

  // level is folded and output enable gated by powerdown before registering; nothing here touches the loop
  for (genvar g = 0; g < 2; g++) begin : g_out
    wire [5:0] code_in = (g == 0) ? link.out_a_level_code : link.out_b_level_code;
    wire off_in = (g == 0) ? link.out_a_select == ODS_SEL_OFF : link.out_b_select == ODS_SEL_OFF;
    wire [5:0] next_level = level_fold(code_in);
    wire next_enabled = !off_in && !pd_now;
    logic [5:0] level_q;
    logic enabled_q;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        level_q <= 6'h00;
        enabled_q <= 1'b0;
      end else begin
        level_q <= next_level;
        enabled_q <= next_enabled;
      end
    end
  end

  assign out_a_level_o = g_out[0].level_q;
  assign out_b_level_o = g_out[1].level_q;
  assign out_a_enabled_o = g_out[0].enabled_q;
  assign out_b_enabled_o = g_out[1].enabled_q;
  // status reuses the powerdown flop instead of keeping a second copy
  assign link.powered_down = pd_q;
  assign calibrating_o = ph == ODS_PH_CAL;
endmodule

// *** hw/ods_host.sv ***
`timescale 1ns/1ps
`include "ods_cfg.svh"
module ods_host (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  ods_if.host link,
  input wire logic [4:0] div_code_i,
  input wire ods_pkg::ods_sel_t out_a_sel_i,
  input wire ods_pkg::ods_sel_t out_b_sel_i,
  input wire logic out_a_used_i,
  input wire logic out_b_used_i,
  input wire logic [5:0] out_a_level_i,
  input wire logic [5:0] out_b_level_i,
  input wire logic sw_pd_i,
  input wire logic pin_pd_i,
  input wire logic sync_use_i,
  input wire logic sync_critical_i,
  input wire logic sync_req_i,
  input wire logic frac_mode_i,
  input wire logic [7:0] modulator_reset_count_i,
  output logic aligned_o,
  output logic pd_status_o
);
  import ods_pkg::*;
  logic pd_q;
  logic sync_sw;
  wire pd_now = sw_pd_i || pin_pd_i;
  wire soft_sync = sync_req_i && !sync_critical_i;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link.chan_div_code <= 5'h00;
      link.out_a_select <= ODS_SEL_VCO;
      link.out_b_select <= ODS_SEL_VCO;
      link.out_a_level_code <= 6'h00;
      link.out_b_level_code <= 6'h00;
      link.pd_bit <= 1'b0;
      link.cal_pin <= 1'b1;
      link.cal_start_bit <= 1'b0;
      link.phase_sync_en <= 1'b0;
      link.align_pin_mask <= 1'b1;
      link.sync_pin <= 1'b0;
      link.frac_mode <= 1'b0;
      link.modulator_reset_count <= 8'h00;
      pd_q <= 1'b0;
      sync_sw <= 1'b0;
    end else begin
      // out-of-range codes are clamped rather than ever reaching the pins
      link.chan_div_code <= (div_code_i > `ODS_CODE_MAX) ? `ODS_CODE_MAX : div_code_i;
      link.out_a_select <= out_a_used_i ? out_a_sel_i : ODS_SEL_VCO;
      link.out_b_select <= out_b_used_i ? out_b_sel_i : ODS_SEL_VCO;
      link.out_a_level_code <= out_a_level_i;
      link.out_b_level_code <= out_b_level_i;
      link.pd_bit <= sw_pd_i;
      link.cal_pin <= !pin_pd_i;
      pd_q <= pd_now;
      link.cal_start_bit <= pd_q && !pd_now;
      sync_sw <= soft_sync;
      link.phase_sync_en <= sync_use_i && !(soft_sync && !sync_sw);
      link.align_pin_mask <= !sync_use_i;
      link.sync_pin <= sync_use_i && sync_critical_i && sync_req_i;
      link.frac_mode <= frac_mode_i;
      link.modulator_reset_count <= modulator_reset_count_i;
    end
  end

  assign aligned_o = link.phase_aligned;
  assign pd_status_o = link.powered_down;
endmodule

// *** verif/ods_properties.sv ***
`timescale 1ns/1ps
`include "ods_cfg.svh"
module ods_properties #(
  parameter int CAL_CYC = `ODS_CAL_CYC,
  parameter int SETTLE_CYC = `ODS_SETTLE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] chan_div_code,
  input wire logic pd_bit,
  input wire logic cal_pin,
  input wire logic cal_start_bit,
  input wire logic phase_sync_en,
  input wire logic align_pin_mask,
  input wire logic sync_pin,
  input wire logic frac_mode,
  input wire logic phase_aligned,
  input wire logic powered_down
);
  localparam int LO = CAL_CYC + SETTLE_CYC;
  localparam int HI = LO + 8;
  localparam int PLO = LO + 2;
  localparam int PHI = HI + 4;
  logic [7:0] since_trig;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // saturating age of the newest sync or cal trigger, so alignment can never appear early
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) since_trig <= 8'h00;
    else if ($rose(phase_sync_en) || $rose(cal_start_bit) || ($rose(sync_pin) && !align_pin_mask)) since_trig <= 8'h00;
    else if (since_trig != 8'hFF) since_trig <= since_trig + 8'h01;
  end
  property p_code_legal; chan_div_code <= 5'h0D; endproperty
  a_code_legal: assert property (p_code_legal) else $error("divide code out of range");
  property p_mask_off; !phase_sync_en [*2] |-> align_pin_mask; endproperty
  a_mask_off: assert property (p_mask_off) else $error("sync pin not masked");
  property p_pd_enter; (pd_bit || !cal_pin) |-> ##[1:2] powered_down; endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("powerdown not entered");
  property p_recal; ($fell(pd_bit) || $rose(cal_pin)) |-> ##[0:8] cal_start_bit; endproperty
  a_recal: assert property (p_recal) else $error("no recalibration after release");
  property p_not_early; $rose(phase_aligned) |-> since_trig >= LO; endproperty
  a_not_early: assert property (p_not_early) else $error("alignment too early");
  property p_soft_sync; ($rose(phase_sync_en) && !frac_mode && !powered_down) |-> ##[LO:HI] phase_aligned; endproperty
  a_soft_sync: assert property (p_soft_sync) else $error("soft sync never aligned");
  property p_pin_sync; ($rose(sync_pin) && phase_sync_en && !align_pin_mask && !frac_mode) |-> ##[PLO:PHI] phase_aligned;
  endproperty
  a_pin_sync: assert property (p_pin_sync) else $error("pin sync never aligned");
  property p_pd_drop; powered_down |-> ##[0:1] !phase_aligned; endproperty
  a_pd_drop: assert property (p_pd_drop) else $error("aligned in powerdown");
endmodule

// *** verif/test_output_divider_phase_sync.sv ***
`timescale 1ns/1ps
module test_output_divider_phase_sync;
  import ods_pkg::*;
  localparam int CAL = 4;
  localparam int SETTLE = 4;
  localparam logic [7:0] RAT [14] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20, 8'h30, 8'h40, 8'h48,
    8'h60, 8'h80, 8'hC0};
  // nibbles hold second, third and fourth stage
  localparam logic [11:0] SEG [14] = '{12'h111, 12'h211, 12'h311, 12'h221, 12'h321, 12'h241, 12'h341, 12'h281,
    12'h381, 12'h282, 12'h362, 12'h382, 12'h284, 12'h384};
  logic ref_clk_i = 1'b0, reset_n_i = 1'b0, a_used = 1'b1, b_used = 1'b1, sw_pd = 1'b0, pin_pd = 1'b0;
  logic sync_use = 1'b0, critical = 1'b0, req = 1'b0, frac = 1'b0;
  logic [4:0] code = 5'h00;
  logic [5:0] lvl_a = 6'h00, lvl_b = 6'h00;
  logic [7:0] mcnt = 8'h05, ratio;
  ods_sel_t sel_a = ODS_SEL_VCO, sel_b = ODS_SEL_VCO;
  logic [1:0] s1, s2;
  logic [3:0] s3;
  logic [2:0] s4, xdiv;
  logic [5:0] lva, lvb;
  logic cvalid, dpow, ena, enb, calb, sev, aligned, pdst;
  int n_errors = 0, num_checks = 0, cycles = 0, n, w;
  ods_if link();
  ods_device #(.CAL_CYC(CAL), .SETTLE_CYC(SETTLE)) i_ods_device (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .link(link), .total_ratio_o(ratio), .div_stage_first_o(s1), .div_stage_second_o(s2), .div_stage_third_o(s3),
    .div_stage_fourth_o(s4), .code_valid_o(cvalid), .div_powered_o(dpow), .feedback_extra_div_o(xdiv),
    .out_a_level_o(lva), .out_b_level_o(lvb), .out_a_enabled_o(ena), .out_b_enabled_o(enb), .calibrating_o(calb),
    .sync_event_o(sev));
  ods_host i_ods_host (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .link(link), .div_code_i(code),
    .out_a_sel_i(sel_a), .out_b_sel_i(sel_b), .out_a_used_i(a_used), .out_b_used_i(b_used), .out_a_level_i(lvl_a),
    .out_b_level_i(lvl_b), .sw_pd_i(sw_pd), .pin_pd_i(pin_pd), .sync_use_i(sync_use), .sync_critical_i(critical),
    .sync_req_i(req), .frac_mode_i(frac), .modulator_reset_count_i(mcnt), .aligned_o(aligned), .pd_status_o(pdst));
  ods_properties #(.CAL_CYC(CAL), .SETTLE_CYC(SETTLE)) i_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .chan_div_code(link.chan_div_code), .pd_bit(link.pd_bit), .cal_pin(link.cal_pin),
    .cal_start_bit(link.cal_start_bit), .phase_sync_en(link.phase_sync_en), .align_pin_mask(link.align_pin_mask),
    .sync_pin(link.sync_pin), .frac_mode(link.frac_mode), .phase_aligned(link.phase_aligned),
    .powered_down(link.powered_down));
  initial forever #10 ref_clk_i = ~ref_clk_i;
  task cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask
  task chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // a lost pulse leaves w at its bound and the pulse check below fails
  task sync_time(output int t);
    @(posedge ref_clk_i) req <= 1'b1;
    @(posedge ref_clk_i) req <= 1'b0;
    #1;
    w = 0;
    t = 0;
    while (sev !== 1'b1 && w < 40) begin
      cyc(1);
      w++;
    end
    chk(12'(sev), 12'h001);
    while (aligned !== 1'b1 && t < 100) begin
      cyc(1);
      t++;
    end
  endtask
  function automatic logic [5:0] fold(input int x);
    return 6'((x >= 32 && x <= 47) ? 31 : x);
  endfunction
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      wrap_up;
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    cyc(2);
    chk(12'(xdiv), 12'h001);
    chk(12'(link.align_pin_mask), 12'h001);
    @(posedge ref_clk_i);
    sel_a <= ODS_SEL_DIV;
    sync_use <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      @(posedge ref_clk_i) code <= 5'(i);
      cyc(4);
      chk(12'(ratio), 12'(RAT[i]));
      chk({s1, s2, s3, s4, 1'b0}, {2'h2, SEG[i][9:8], SEG[i][7:4], SEG[i][2:0], 1'b0});
      chk(12'(xdiv), (RAT[i] % 3 == 0 && RAT[i] != 8'h18 && RAT[i] != 8'hC0) ? 12'h006 : 12'h004);
    end
    @(posedge ref_clk_i) code <= 5'h14;
    cyc(4);
    chk(12'(cvalid), 12'h001);
    chk(12'(ratio), 12'h0C0);
    for (int k = 0; k < 16; k++) begin
      @(posedge ref_clk_i);
      sel_a <= ods_sel_t'(k[1:0]);
      sel_b <= ods_sel_t'(k[3:2]);
      cyc(4);
      chk(12'(dpow), 12'(k[1:0] == ODS_SEL_DIV || k[3:2] == ODS_SEL_DIV || k[3:2] == ODS_SEL_SYSREF));
      if (k == 5) chk(12'(xdiv), 12'h001);
      chk(12'({ena, enb}), 12'({k[1:0] != ODS_SEL_OFF, k[3:2] != ODS_SEL_OFF}));
    end
    @(posedge ref_clk_i);
    a_used <= 1'b0;
    sel_a <= ODS_SEL_DIV;
    sel_b <= ODS_SEL_VCO;
    cyc(4);
    chk(12'(link.out_a_select), 12'(ODS_SEL_VCO));
    @(posedge ref_clk_i) a_used <= 1'b1;
    sync_time(n);
    chk(12'(n), 12'(CAL + SETTLE));
    for (int v = 0; v < 64; v++) begin
      @(posedge ref_clk_i);
      lvl_a <= 6'(v);
      lvl_b <= 6'(63 - v);
      cyc(3);
      chk({lva, lvb}, {fold(v), fold(63 - v)});
      chk(12'(aligned), 12'h001);
    end
    @(posedge ref_clk_i) frac <= 1'b1;
    sync_time(n);
    chk(12'(n), 12'(CAL + SETTLE + 5 + 1));
    @(posedge ref_clk_i);
    frac <= 1'b0;
    critical <= 1'b1;
    cyc(3);
    chk(12'(link.align_pin_mask), 12'h000);
    sync_time(n);
    chk(12'(n), 12'(CAL + SETTLE));
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk_i);
      sw_pd <= (p == 0);
      pin_pd <= (p == 1);
      cyc(4);
      chk(12'({pdst, aligned, ena, enb}), 12'h008);
      @(posedge ref_clk_i);
      sw_pd <= 1'b0;
      pin_pd <= 1'b0;
      cyc(1);
      w = 0;
      while (calb !== 1'b1 && w < 20) begin
        cyc(1);
        w++;
      end
      chk(12'(calb), 12'h001);
      chk(12'(pdst), 12'h000);
    end
    // mid-run reset: decode and status return to reset values, then the enable edge realigns
    @(posedge ref_clk_i) reset_n_i <= 1'b0;
    cyc(2);
    chk({ratio, xdiv, aligned}, {8'h02, 3'h1, 1'b0});
    chk(12'({pdst, calb, sev}), 12'h000);
    @(posedge ref_clk_i) reset_n_i <= 1'b1;
    cyc(1);
    n = 0;
    while (aligned !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk(12'(n), 12'(CAL + SETTLE + 1));
    wrap_up;
  end
endmodule
